// file: hdl/roak_pkg.sv
// constants, register map and timing for the release-on-acknowledge interrupter
`default_nettype none
package roak_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_DELAY_NS = 25;
    localparam int DATA_SETUP_NS = 10;
    localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC_RAW = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
    localparam logic [3:0] AS_D25 = 4'(STROBE_DELAY_CYC);
    localparam logic [3:0] AS_D50 = 4'(2 * STROBE_DELAY_CYC);
    localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);

    // ------------------------------------------------------------
    // widths and register map (byte addresses)
    // ------------------------------------------------------------
    localparam int EV_ONE_W = 8;
    localparam int EV_TWO_W = 5;
    localparam int EV_W = EV_ONE_W + EV_TWO_W;
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADR_EV_ONE = 6'h00;
    localparam logic [5:0] ADR_EV_TWO = 6'h04;
    localparam logic [5:0] ADR_MASK_ONE = 6'h08;
    localparam logic [5:0] ADR_MASK_TWO = 6'h0c;
    localparam logic [5:0] ADR_PRIORITY = 6'h10;
    localparam logic [5:0] ADR_STATUS_ID = 6'h14;
    localparam logic [5:0] ADR_STATE = 6'h18;
    localparam logic [5:0] ADR_IRQ_STAT = 6'h1c;
    localparam logic [5:0] ADR_IRQ_EN = 6'h20;
    localparam logic [5:0] ADR_IRQ_CLR = 6'h24;
    localparam logic [2:0] PRIORITY_RST = 3'h1;
    localparam logic [7:0] STATUS_ID_RST = 8'h00;

    // interrupt status bit positions
    localparam int IRQ_W = 3;
    localparam int IB_VECTOR = 0;
    localparam int IB_PASSED = 1;
    localparam int IB_RAISED = 2;
endpackage
`default_nettype wire

// file: hdl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);

    // a bit changes only when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= (agree & s3_r) | (~agree & level_r);
        end
    end
    assign level = level_r;
endmodule
`default_nettype wire

// file: hdl/roak_interrupter.sv
// release-on-acknowledge bus interrupter with event status and avalon slave
`timescale 1ns/1ns
`default_nettype none
module roak_interrupter
    import roak_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // controller chip events, one-cycle pulses on sys_clk
    input wire logic [EV_W-1:0] chip_events,
    // read/write acknowledge request from the transfer logic
    input wire logic rw_ack_request,
    // backplane pins
    input wire logic as_n,
    input wire logic ds0_n,
    input wire logic ds1_n,
    input wire logic iack_n,
    input wire logic iackin_n,
    input wire logic [2:0] addr_lvl,
    input wire logic dtack_in_n,
    output logic dtack_o,
    output logic dtack_oe,
    output logic irq_req_o,
    output logic irq_req_oe,
    output logic iackout_n,
    output logic [7:0] data_o,
    output logic data_buffer_enable,
    output logic gpib_controller_chip_int
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int PIN_W = 9;
    logic [PIN_W-1:0] pin_lvl;

    pin_sync #(.W(PIN_W), .RST_VAL(9'h1f8)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin({as_n, ds0_n, ds1_n, iack_n, iackin_n, dtack_in_n, addr_lvl}),
        .level(pin_lvl)
    );

    wire as_act = ~pin_lvl[8];
    wire ds0_act = ~pin_lvl[7];
    wire ds1_act = ~pin_lvl[6];
    wire iack_act = ~pin_lvl[5];
    wire iackin_act = ~pin_lvl[4];
    wire dtack_seen = ~pin_lvl[3];
    wire [2:0] ack_level = pin_lvl[2:0];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [EV_ONE_W-1:0] ev_one_r;
    logic [EV_TWO_W-1:0] ev_two_r;
    logic [EV_ONE_W-1:0] mask_one_r;
    logic [EV_TWO_W-1:0] mask_two_r;
    logic [2:0] priority_r;
    logic [7:0] status_id_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [31:0] rdata_r;
    logic wait_r;
    logic irq_r;

    // interrupter state
    logic [3:0] as_cnt_r;
    logic decided_r;
    logic match_r;
    logic vector_enable_r;
    logic [3:0] setup_cnt_r;
    logic vector_ack_request_r;
    logic dtack_r;
    logic irq_drive_r;
    logic armed_r;
    logic iackout_r;
    logic chip_int_r;
    logic [7:0] data_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
        return a == off;
    endfunction

    wire req = avs_read | avs_write;
    wire capture = avs_read & wait_r;
    wire wr_take = avs_write & ~wait_r;
    // status clears when its value is captured for the answer
    wire rd_ev_one = capture & hit(avs_address, ADR_EV_ONE);
    wire rd_ev_two = capture & hit(avs_address, ADR_EV_TWO);
    wire wr_mask_one = wr_take & hit(avs_address, ADR_MASK_ONE);
    wire wr_mask_two = wr_take & hit(avs_address, ADR_MASK_TWO);
    wire wr_priority = wr_take & hit(avs_address, ADR_PRIORITY);
    wire wr_status_id = wr_take & hit(avs_address, ADR_STATUS_ID);
    wire wr_irq_en = wr_take & hit(avs_address, ADR_IRQ_EN);
    wire wr_irq_clr = wr_take & hit(avs_address, ADR_IRQ_CLR);

    wire [EV_ONE_W-1:0] ev_one_in = chip_events[EV_ONE_W-1:0];
    wire [EV_TWO_W-1:0] ev_two_in = chip_events[EV_W-1:EV_ONE_W];

    wire [31:0] state_word = {26'h0, chip_int_r, irq_drive_r, iackout_r,
        vector_enable_r, match_r, decided_r};

    wire [31:0] rdata_nxt =
        hit(avs_address, ADR_EV_ONE) ? {24'h0, ev_one_r} :
        hit(avs_address, ADR_EV_TWO) ? {27'h0, ev_two_r} :
        hit(avs_address, ADR_MASK_ONE) ? {24'h0, mask_one_r} :
        hit(avs_address, ADR_MASK_TWO) ? {27'h0, mask_two_r} :
        hit(avs_address, ADR_PRIORITY) ? {29'h0, priority_r} :
        hit(avs_address, ADR_STATUS_ID) ? {24'h0, status_id_r} :
        hit(avs_address, ADR_STATE) ? state_word :
        hit(avs_address, ADR_IRQ_STAT) ? {29'h0, irq_stat_r} :
        hit(avs_address, ADR_IRQ_EN) ? {29'h0, irq_en_r} : 32'h0;

    // ------------------------------------------------------------
    // event status and chip interrupt
    // ------------------------------------------------------------
    // a new event in the clearing cycle survives the clear
    wire [EV_ONE_W-1:0] ev_one_nxt = (rd_ev_one ? '0 : ev_one_r) | ev_one_in;
    wire [EV_TWO_W-1:0] ev_two_nxt = (rd_ev_two ? '0 : ev_two_r) | ev_two_in;
    // masks only gate the interrupt, never the status bits
    wire chip_int_nxt = |(ev_one_r & mask_one_r) | |(ev_two_r & mask_two_r);

    // ------------------------------------------------------------
    // interrupter decisions
    // ------------------------------------------------------------
    wire as_d25 = as_cnt_r >= AS_D25;
    wire as_d50 = as_cnt_r >= AS_D50;
    wire [3:0] as_cnt_nxt = ~as_act ? 4'h0 : (as_d50 ? as_cnt_r : as_cnt_r + 4'h1);
    wire cmp_eq = ack_level == priority_r;
    wire latch_cmp = as_act & iack_act & (as_cnt_r == AS_D25) & ~decided_r;
    // dtack from someone else must be gone before the vector goes out
    wire vec_start = decided_r & match_r & iackin_act & ds0_act & as_d50
        & ~dtack_seen & ~vector_enable_r;
    wire vec_end = vector_enable_r & ~ds0_act;
    wire pass_on = decided_r & ~match_r & iackin_act & as_d50;
    wire setup_done = setup_cnt_r == SETUP_CNT;
    // release-on-acknowledge: once served, stay quiet until the chip drops its line
    wire irq_drive_nxt = chip_int_r & armed_r & ~vec_end;
    wire armed_nxt = vec_end ? 1'b0 : (~chip_int_r ? 1'b1 : armed_r);
    wire dtack_release = ~vector_ack_request_r & ~rw_ack_request & ~vector_enable_r
        & ~ds0_act & ~ds1_act;
    wire dtack_nxt = rw_ack_request | vector_ack_request_r
        | (dtack_r & ~dtack_release);

    wire [IRQ_W-1:0] irq_events;
    assign irq_events[IB_VECTOR] = vec_start;
    assign irq_events[IB_PASSED] = pass_on & iackout_r;
    assign irq_events[IB_RAISED] = irq_drive_nxt & ~irq_drive_r;
    wire [IRQ_W-1:0] irq_clr_bits = wr_irq_clr ? avs_writedata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr_bits) | irq_events;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // one wait cycle per access, answer at the second edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= ~(req & wait_r);
            if (capture) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_one_r <= '0;
            mask_two_r <= '0;
            priority_r <= PRIORITY_RST;
            status_id_r <= STATUS_ID_RST;
            irq_en_r <= '0;
        end else begin
            if (wr_mask_one) begin
                mask_one_r <= avs_writedata[EV_ONE_W-1:0];
            end
            if (wr_mask_two) begin
                mask_two_r <= avs_writedata[EV_TWO_W-1:0];
            end
            if (wr_priority) begin
                priority_r <= avs_writedata[2:0];
            end
            if (wr_status_id) begin
                status_id_r <= avs_writedata[7:0];
            end
            if (wr_irq_en) begin
                irq_en_r <= avs_writedata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ev_one_r <= '0;
            ev_two_r <= '0;
            chip_int_r <= 1'b0;
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            ev_one_r <= ev_one_nxt;
            ev_two_r <= ev_two_nxt;
            chip_int_r <= chip_int_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // acknowledge cycle
    // ------------------------------------------------------------
    // system reset puts every piece of the interrupter at rest
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            as_cnt_r <= 4'h0;
            decided_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            as_cnt_r <= as_cnt_nxt;
            if (~as_act) begin
                decided_r <= 1'b0;
                match_r <= 1'b0;
            end else if (latch_cmp) begin
                decided_r <= 1'b1;
                match_r <= cmp_eq;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vector_enable_r <= 1'b0;
            setup_cnt_r <= 4'h0;
            vector_ack_request_r <= 1'b0;
            data_r <= 8'h00;
        end else begin
            if (vec_start) begin
                vector_enable_r <= 1'b1;
                data_r <= status_id_r;
            end else if (vec_end) begin
                vector_enable_r <= 1'b0;
            end
            if (~vector_enable_r | vec_end) begin
                setup_cnt_r <= 4'h0;
            end else if (~setup_done) begin
                setup_cnt_r <= setup_cnt_r + 4'h1;
            end
            // byte has been on the bus for the set-up time first
            vector_ack_request_r <= vector_enable_r & ~vec_end & setup_done;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dtack_r <= 1'b0;
            irq_drive_r <= 1'b0;
            armed_r <= 1'b1;
            iackout_r <= 1'b0;
        end else begin
            dtack_r <= dtack_nxt;
            irq_drive_r <= irq_drive_nxt;
            armed_r <= armed_nxt;
            // drops as soon as the synchronised strobe is seen released
            iackout_r <= pass_on & as_act;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open-collector lines: the low level is constant, the enable carries the state
    logic low_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_r <= 1'b0;
        end else begin
            low_r <= 1'b0;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;
    assign dtack_o = low_r;
    assign dtack_oe = dtack_r;
    assign irq_req_o = low_r;
    assign irq_req_oe = irq_drive_r;
    assign iackout_n = ~iackout_r;
    assign data_o = data_r;
    assign data_buffer_enable = vector_enable_r;
    assign gpib_controller_chip_int = chip_int_r;
endmodule
`default_nettype wire

// file: sim/roak_interrupter_properties.sv
// concurrent checks on the interrupter backplane and chip interrupt ports
`timescale 1ns/1ns
`default_nettype none
module roak_interrupter_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rw_ack_request,
    input wire logic as_n,
    input wire logic ds0_n,
    input wire logic ds1_n,
    input wire logic iackin_n,
    input wire logic dtack_in_n,
    input wire logic dtack_oe,
    input wire logic irq_req_oe,
    input wire logic iackout_n,
    input wire logic data_buffer_enable,
    input wire logic gpib_controller_chip_int
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_irq_follows; $rose(gpib_controller_chip_int) |=> irq_req_oe; endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("request line late");
    property p_rw_dtack; rw_ack_request |-> ##[0:4] dtack_oe; endproperty
    a_rw_dtack: assert property (p_rw_dtack) else $error("dtack missing");
    // vector data must be on the bus at least two cycles before dtack
    property p_vec_dtack;
        $rose(dtack_oe) && !rw_ack_request |-> $past(data_buffer_enable, 2);
    endproperty
    a_vec_dtack: assert property (p_vec_dtack) else $error("dtack before data");
    property p_vec_needs;
        $rose(data_buffer_enable) |-> !ds0_n && !iackin_n && dtack_in_n;
    endproperty
    a_vec_needs: assert property (p_vec_needs) else $error("vector too early");
    // neither answer may come before the strobe has been low for both delay steps
    property p_wait_50;
        $rose(data_buffer_enable) || $fell(iackout_n) |-> !$past(as_n, 3);
    endproperty
    a_wait_50: assert property (p_wait_50) else $error("answer too early");
    property p_vec_hold; data_buffer_enable && !ds0_n |=> data_buffer_enable; endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector dropped");
    property p_release; $fell(data_buffer_enable) |-> ##[0:1] !irq_req_oe; endproperty
    a_release: assert property (p_release) else $error("request not released");
    property p_dtack_rel;
        $fell(dtack_oe) |-> !data_buffer_enable && ds1_n && !rw_ack_request;
    endproperty
    a_dtack_rel: assert property (p_dtack_rel) else $error("dtack released early");
    property p_pass; $fell(iackout_n) |-> !iackin_n && !data_buffer_enable; endproperty
    a_pass: assert property (p_pass) else $error("bad pass on");
    // sync latency makes this about 100 ns, not 30 ns
    property p_pass_rel; $rose(as_n) |-> ##[0:5] iackout_n; endproperty
    a_pass_rel: assert property (p_pass_rel) else $error("pass not released");
    property p_reset;
        disable iff (1'b0) rst |=> !data_buffer_enable && iackout_n && !irq_req_oe && !dtack_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");
    c_vec: cover property ($rose(data_buffer_enable));
    c_pass: cover property ($fell(iackout_n));
    c_rw: cover property (rw_ack_request && dtack_oe);
endmodule
bind roak_interrupter roak_interrupter_properties chk (.sys_clk(sys_clk), .rst(rst),
    .rw_ack_request(rw_ack_request), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
    .iackin_n(iackin_n), .dtack_in_n(dtack_in_n), .dtack_oe(dtack_oe), .irq_req_oe(irq_req_oe),
    .iackout_n(iackout_n), .data_buffer_enable(data_buffer_enable),
    .gpib_controller_chip_int(gpib_controller_chip_int));
`default_nettype wire

// file: sim/vme_handler_model.sv
// interrupt handler model: runs one acknowledge cycle per start pulse
`timescale 1ns/1ns
`default_nettype none
module vme_handler_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [2:0] level,
    input wire logic [7:0] data_o,
    input wire logic data_buffer_enable,
    input wire logic dtack_oe,
    input wire logic iackout_n,
    output logic as_n,
    output logic ds0_n,
    output logic ds1_n,
    output logic iack_n,
    output logic iackin_n,
    output logic [2:0] addr_lvl,
    output wire logic dtack_in_n,
    output logic busy,
    output logic got_vec,
    output logic passed,
    output logic [7:0] vec
);
    // ------------------------------------------------------------
    // handler sequence
    // ------------------------------------------------------------
    logic [1:0] st_r;
    // open-collector dtack and terminated data lines pull high
    assign dtack_in_n = ~dtack_oe;
    wire logic [7:0] d_bus = data_buffer_enable ? data_o : 8'hff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= 2'h0;
            {as_n, ds0_n, ds1_n, iack_n, iackin_n, busy} <= 6'h3e;
            addr_lvl <= 3'h0;
        end else if (st_r == 2'h0) begin
            if (start) begin
                {as_n, iack_n, addr_lvl, busy, got_vec, passed} <= {2'b00, level, 3'b100};
                st_r <= 2'h1;
            end else begin
                // idle address noise must never reach a latched comparison
                addr_lvl <= ~addr_lvl;
            end
        end else if (st_r == 2'h1) begin
            // byte cycle on ds0 only, ds1 stays high
            {ds0_n, iackin_n} <= 2'b00;
            st_r <= 2'h2;
        end else if (st_r == 2'h2) begin
            if (!dtack_in_n || !iackout_n) begin
                vec <= d_bus;
                got_vec <= !dtack_in_n;
                passed <= !iackout_n;
                {as_n, ds0_n, iack_n, iackin_n} <= 4'hf;
                st_r <= 2'h3;
            end
        end else if (dtack_in_n && iackout_n) begin
            busy <= 1'b0;
            st_r <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// file: sim/vme_roak_interrupter_tb.sv
// self-checking bench for the release-on-acknowledge interrupter
`timescale 1ns/1ns
`default_nettype none
module vme_roak_interrupter_tb;
    import roak_pkg::*;
    logic sys_clk = 0;
    logic rst = 1;
    logic [5:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, rw_ack_request = 0, start = 0, busy, got_vec, passed;
    logic [12:0] chip_events = 0;
    logic [2:0] level = 0, addr_lvl;
    logic as_n, ds0_n, ds1_n, iack_n, iackin_n, dtack_in_n, dtack_o, dtack_oe;
    logic irq_req_o, irq_req_oe, iackout_n, data_buffer_enable, chip_int;
    logic [7:0] data_o, vec;
    int errors = 0;
    int num_checks = 0;
    roak_interrupter dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .chip_events(chip_events), .rw_ack_request(rw_ack_request), .as_n(as_n), .ds0_n(ds0_n),
        .ds1_n(ds1_n), .iack_n(iack_n), .iackin_n(iackin_n), .addr_lvl(addr_lvl),
        .dtack_in_n(dtack_in_n), .dtack_o(dtack_o), .dtack_oe(dtack_oe), .irq_req_o(irq_req_o),
        .irq_req_oe(irq_req_oe), .iackout_n(iackout_n), .data_o(data_o),
        .data_buffer_enable(data_buffer_enable), .gpib_controller_chip_int(chip_int));
    vme_handler_model hdl (.sys_clk(sys_clk), .rst(rst), .start(start), .level(level),
        .data_o(data_o), .data_buffer_enable(data_buffer_enable), .dtack_oe(dtack_oe),
        .iackout_n(iackout_n), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .iack_n(iack_n),
        .iackin_n(iackin_n), .addr_lvl(addr_lvl), .dtack_in_n(dtack_in_n), .busy(busy),
        .got_vec(got_vec), .passed(passed), .vec(vec));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge sys_clk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        r = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic ev(input logic [12:0] v);
        @(posedge sys_clk);
        chip_events <= v;
        @(posedge sys_clk);
        chip_events <= 13'h0;
        cyc(3);
    endtask
    task automatic ack(input logic [2:0] l);
        @(posedge sys_clk);
        {start, level} <= {1'b1, l};
        @(posedge sys_clk);
        start <= 1'b0;
        cyc(2);
        while (busy !== 1'b0) @(posedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_raise;
        chk({irq_req_oe, dtack_oe, data_buffer_enable, iackout_n}, 4'b0001);
        chk({irq, data_o, dtack_o, irq_req_o}, 11'h000);
        wr(ADR_MASK_ONE, 32'h1);
        wr(ADR_STATUS_ID, 32'ha5);
        wr(ADR_PRIORITY, 32'h3);
        wr(ADR_IRQ_EN, 32'h7);
        ev(13'h0001);
        chk({chip_int, irq_req_oe}, 2'b11);
        $display("test raise done");
    endtask
    task automatic t_vector;
        ack(3'h3);
        chk({got_vec, passed, vec}, 10'h2a5);
        chk({irq_req_oe, dtack_oe, data_buffer_enable}, 3'b000);
        rd(ADR_IRQ_STAT, 32'h5);
        chk(irq, 1'b1);
        wr(ADR_IRQ_CLR, 32'h7);
        cyc(1);
        chk({irq, irq_req_oe, chip_int}, 3'b001);
        $display("test vector done");
    endtask
    task automatic t_clear;
        rd(ADR_EV_ONE, 32'h1);
        rd(ADR_EV_ONE, 32'h0);
        cyc(2);
        chk(chip_int, 1'b0);
        $display("test clear done");
    endtask
    task automatic t_pass;
        ack(3'h5);
        chk({got_vec, passed, iackout_n, data_buffer_enable}, 4'b0110);
        rd(ADR_IRQ_STAT, 32'h2);
        $display("test pass done");
    endtask
    task automatic t_mask;
        ev(13'h0200);
        chk({chip_int, irq_req_oe}, 2'b00);
        rd(ADR_EV_TWO, 32'h2);
        rd(6'h3c, 32'h0);
        rd(ADR_PRIORITY, 32'h3);
        $display("test mask done");
    endtask
    task automatic t_rw;
        @(posedge sys_clk);
        rw_ack_request <= 1'b1;
        cyc(5);
        chk(dtack_oe, 1'b1);
        rw_ack_request <= 1'b0;
        cyc(5);
        chk(dtack_oe, 1'b0);
        $display("test rw done");
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        t_raise;
        t_vector;
        t_clear;
        t_pass;
        t_mask;
        t_rw;
        final_report;
    end
endmodule
`default_nettype wire
